// ### axis_check_pkg.sv
`default_nettype none
package axis_check_pkg;
  localparam int NUM_AXES = 16;
  localparam int AXIS_W   = 4;
  localparam int POS_W    = 32;
  localparam int SPD_W    = 32;
  localparam int TIME_W   = 16;
  localparam int SEG_W    = 8;
  localparam int SEG_AX_W = 5;

  // permitted ranges of a relative command
  localparam logic signed [POS_W-1:0] REL_POS_MIN = 32'shc000_0001;
  localparam logic signed [POS_W-1:0] REL_POS_MAX = 32'sh3fff_ffff;
  localparam logic signed [POS_W-1:0] FEED_ZERO   = 32'sh0000_0000;
  localparam logic [SPD_W-1:0]  SPEED_MIN = 32'h0000_0001;
  localparam logic [SPD_W-1:0]  SPEED_MAX = 32'h3fff_ffff;
  localparam logic [TIME_W-1:0] ACC_MAX   = 16'h2710;
  localparam logic [TIME_W-1:0] DEC_MAX   = 16'h2710;

  // segment display: error code then axis number 1..16
  localparam logic [SEG_W-1:0]    SEG_CODE_ERR = 8'hae;
  localparam logic [SEG_W-1:0]    SEG_BLANK    = 8'h00;
  localparam logic [SEG_AX_W-1:0] SEG_AX_NONE  = 5'h00;
  localparam logic [SEG_AX_W-1:0] SEG_AX_BASE  = 5'h01;

  typedef enum logic [1:0] {
    CMD_REL_MOVE,
    CMD_REL_FEED,
    CMD_ABS_FEED,
    CMD_OTHER
  } cmd_type_t;

  typedef enum logic [3:0] {
    ERR_NONE,
    ERR_ABS_FUNC,
    ERR_ABS_NO_INTR,
    ERR_ABS_OVF,
    ERR_REL_POS,
    ERR_REL_SPEED,
    ERR_REL_ACC,
    ERR_REL_DEC,
    ERR_REL_FEED_POS,
    ERR_REL_FUNC,
    ERR_REL_NO_INTR,
    ERR_REL_OVF
  } err_kind_t;

  typedef enum logic [1:0] {
    AX_IDLE,
    AX_WAIT_INTR,
    AX_FED
  } axis_state_t;

  function automatic logic stops_axis(input err_kind_t k);
    stops_axis = !(k inside {ERR_NONE, ERR_ABS_FUNC, ERR_REL_FUNC,
                             ERR_ABS_NO_INTR, ERR_REL_NO_INTR});
  endfunction : stops_axis
endpackage : axis_check_pkg
`default_nettype wire

// ### axis_link_if.sv
`default_nettype none
interface axis_link_if;
  import axis_check_pkg::*;
  logic      cmd_stb;
  err_kind_t cmd_kind;
  logic      cmd_feed;
  logic      cmd_abs;
  logic      fb_ovf;
  logic      move_done;
  logic      err_rst;
  logic      err_active;
  err_kind_t err_kind;
  logic      stop;
  logic      busy;

  modport ctrl (
    output cmd_stb, cmd_kind, cmd_feed, cmd_abs, fb_ovf, move_done, err_rst,
    input  err_active, err_kind, stop, busy
  );
  modport unit (
    input  cmd_stb, cmd_kind, cmd_feed, cmd_abs, fb_ovf, move_done, err_rst,
    output err_active, err_kind, stop, busy
  );
endinterface : axis_link_if
`default_nettype wire

// ### axis_fault_unit.sv
`default_nettype none
module axis_fault_unit
  import axis_check_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  input  wire logic  enable_i,
  input  wire logic  intr_pin_i,
  axis_link_if.unit  lnk
);
  logic        pin_meta;
  logic        pin_sync;
  logic        pin_prev;
  logic        feed_abs;
  axis_state_t state;
  axis_state_t next_state;

  wire logic      pin_edge  = pin_sync & ~pin_prev;
  wire logic      idle      = (state == AX_IDLE);
  wire logic      feeding   = !idle;
  wire logic      cmd_fault = lnk.cmd_stb & idle & !lnk.err_active &
                              (lnk.cmd_kind != ERR_NONE);
  // overflow only counts while feeding is under way
  wire logic      ovf_fault = feeding & lnk.fb_ovf;
  wire logic      miss      = (state == AX_WAIT_INTR) & lnk.move_done &
                              ~pin_edge;
  wire err_kind_t ovf_kind  = feed_abs ? ERR_ABS_OVF : ERR_REL_OVF;
  wire err_kind_t miss_kind = feed_abs ? ERR_ABS_NO_INTR : ERR_REL_NO_INTR;
  wire err_kind_t raise_kind = lnk.err_active ? ERR_NONE :
                               ovf_fault ? ovf_kind :
                               miss ? miss_kind :
                               cmd_fault ? lnk.cmd_kind : ERR_NONE;
  wire logic      raise     = (raise_kind != ERR_NONE);
  wire logic      start     = lnk.cmd_stb & idle & !lnk.err_active &
                              (lnk.cmd_kind == ERR_NONE) & lnk.cmd_feed;

  assign lnk.busy = feeding;

  always_comb
  begin
    next_state = state;
    unique case (state)
      AX_IDLE:      if (start) next_state = AX_WAIT_INTR;
      AX_WAIT_INTR: if (pin_edge) next_state = AX_FED;
      AX_FED:       if (lnk.move_done) next_state = AX_IDLE;
      default:      next_state = AX_IDLE;
    endcase
    if (raise)
      next_state = AX_IDLE;
  end

  // pin crosses in through two flops; only the second is looked at
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else if (enable_i)
    begin
      pin_meta <= intr_pin_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state    <= AX_IDLE;
      feed_abs <= 1'b0;
    end
    else if (enable_i)
    begin
      state <= next_state;
      if (start)
        feed_abs <= lnk.cmd_abs;
    end
  end

  // a new fault beats a reset landing in the same cycle
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      lnk.err_active <= 1'b0;
      lnk.err_kind   <= ERR_NONE;
      lnk.stop       <= 1'b0;
    end
    else if (enable_i)
    begin
      if (raise)
      begin
        lnk.err_active <= 1'b1;
        lnk.err_kind   <= raise_kind;
        lnk.stop       <= stops_axis(raise_kind);
      end
      else if (lnk.err_rst)
      begin
        lnk.err_active <= 1'b0;
        lnk.err_kind   <= ERR_NONE;
        lnk.stop       <= 1'b0;
      end
    end
  end

  sequence s_feed_missed;
    enable_i && !lnk.err_active && miss && !ovf_fault;
  endsequence

  property p_hold;
    @(posedge clk_i) disable iff (reset_i)
    lnk.err_active && !lnk.err_rst |=> lnk.err_active;
  endproperty
  a_hold: assert property (p_hold)
    else $error("held error dropped without reset");

  property p_clear_cause;
    @(posedge clk_i) disable iff (reset_i)
    $fell(lnk.err_active) |-> $past(lnk.err_rst) && $past(enable_i);
  endproperty
  a_clear_cause: assert property (p_clear_cause)
    else $error("error cleared without error reset");

  property p_stop_kind;
    @(posedge clk_i) disable iff (reset_i)
    lnk.err_active |-> (lnk.stop == stops_axis(lnk.err_kind));
  endproperty
  a_stop_kind: assert property (p_stop_kind)
    else $error("stop request does not match error kind");

  property p_no_intr;
    @(posedge clk_i) disable iff (reset_i)
    s_feed_missed |=> lnk.err_active && !lnk.stop &&
      (lnk.err_kind == ($past(feed_abs) ? ERR_ABS_NO_INTR : ERR_REL_NO_INTR));
  endproperty
  a_no_intr: assert property (p_no_intr)
    else $error("missing interrupt not flagged");

  property p_ovf;
    @(posedge clk_i) disable iff (reset_i)
    enable_i && feeding && lnk.fb_ovf && !lnk.err_active
      |=> lnk.err_active && lnk.stop && idle;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("feedback overflow not flagged with stop");

  property p_own_cause;
    @(posedge clk_i) disable iff (reset_i)
    $rose(lnk.stop) |-> $past(lnk.cmd_stb || (feeding && lnk.fb_ovf));
  endproperty
  a_own_cause: assert property (p_own_cause)
    else $error("axis stopped without a cause of its own");
endmodule : axis_fault_unit
`default_nettype wire

// ### axis_move_command_checker.sv
// Behaviour
// - on a fault light run and error lamps, show AE and axis 1..16
// - refuse interrupt feeding when the axis input is set for latch use
// - flag missing interrupt when feeding ends with no interrupt seen
// - flag feedback position overflow or underflow during interrupt feeding
// - flag relative target position outside its permitted range
// - flag relative move speed outside its permitted range
// - flag relative move acceleration time outside its permitted range
// - flag relative move deceleration time outside its permitted range
// - relative feed position error when out of range or zero travel
// - overflow, position, speed and time errors decelerate the axis to stop
// - each error holds until the host issues error reset for the axis
`default_nettype none
module axis_move_command_checker
  import axis_check_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   enable_i,
  input  wire logic                   cmd_valid_i,
  input  wire logic [AXIS_W-1:0]      cmd_axis_i,
  input  wire cmd_type_t              cmd_type_i,
  input  wire logic signed [POS_W-1:0] cmd_position_i,
  input  wire logic [SPD_W-1:0]       cmd_speed_i,
  input  wire logic [TIME_W-1:0]      cmd_accel_i,
  input  wire logic [TIME_W-1:0]      cmd_decel_i,
  input  wire logic                   err_reset_i,
  input  wire logic [AXIS_W-1:0]      err_reset_axis_i,
  input  wire logic [NUM_AXES-1:0]    intr_func_latch_i,
  input  wire logic [NUM_AXES-1:0]    intr_pin_i,
  input  wire logic [NUM_AXES-1:0]    fb_overflow_i,
  input  wire logic [NUM_AXES-1:0]    move_done_i,
  output logic                        run_led_o,
  output logic                        controller_error_led_o,
  output logic [SEG_W-1:0]            segment_display_code_o,
  output logic [SEG_AX_W-1:0]         segment_display_axis_o,
  output logic [NUM_AXES-1:0]         axis_error_o,
  output logic [NUM_AXES-1:0]         axis_stop_o,
  output logic                        cmd_accept_o,
  output logic                        cmd_reject_o
);
  logic [NUM_AXES-1:0] axis_err;
  logic [NUM_AXES-1:0] axis_busy;
  err_kind_t           axis_kind [NUM_AXES];
  logic [AXIS_W-1:0]   first_axis;

  // one checker serves all axes: only one command arrives per cycle
  wire logic is_feed  = (cmd_type_i == CMD_REL_FEED) ||
                        (cmd_type_i == CMD_ABS_FEED);
  wire logic is_rel   = (cmd_type_i == CMD_REL_MOVE) ||
                        (cmd_type_i == CMD_REL_FEED);
  wire logic known    = (cmd_type_i != CMD_OTHER);
  wire logic latch_sel = intr_func_latch_i[cmd_axis_i];
  wire logic func_bad = is_feed & latch_sel;
  wire logic pos_bad  = is_rel & ((cmd_position_i < REL_POS_MIN) ||
                                  (cmd_position_i > REL_POS_MAX));
  wire logic zero_bad = (cmd_type_i == CMD_REL_FEED) &
                        (cmd_position_i == FEED_ZERO);
  wire logic spd_bad  = is_rel & ((cmd_speed_i < SPEED_MIN) ||
                                  (cmd_speed_i > SPEED_MAX));
  wire logic acc_bad  = is_rel & (cmd_accel_i > ACC_MAX);
  wire logic dec_bad  = is_rel & (cmd_decel_i > DEC_MAX);
  wire logic feed_pos_bad = (cmd_type_i == CMD_REL_FEED) &
                            (pos_bad | zero_bad);

  // setting error first: the feed is refused before any range check
  wire err_kind_t cmd_kind =
    func_bad ? ((cmd_type_i == CMD_ABS_FEED) ? ERR_ABS_FUNC
                                             : ERR_REL_FUNC) :
    feed_pos_bad ? ERR_REL_FEED_POS :
    pos_bad ? ERR_REL_POS :
    spd_bad ? ERR_REL_SPEED :
    acc_bad ? ERR_REL_ACC :
    dec_bad ? ERR_REL_DEC : ERR_NONE;

  wire logic take = cmd_valid_i & known & !axis_err[cmd_axis_i] &
                    !axis_busy[cmd_axis_i];
  wire logic good = take & (cmd_kind == ERR_NONE);
  wire logic any_err = |axis_err;

  always_comb
  begin
    first_axis = '0;
    for (int i = NUM_AXES - 1; i >= 0; i--)
      if (axis_err[i])
        first_axis = AXIS_W'(i);
  end

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++)
    begin : g_axis
      axis_link_if lnk ();

      assign lnk.cmd_stb   = take & (cmd_axis_i == AXIS_W'(g));
      assign lnk.cmd_kind  = cmd_kind;
      assign lnk.cmd_feed  = is_feed;
      assign lnk.cmd_abs   = (cmd_type_i == CMD_ABS_FEED);
      assign lnk.fb_ovf    = fb_overflow_i[g];
      assign lnk.move_done = move_done_i[g];
      assign lnk.err_rst   = err_reset_i &
                             (err_reset_axis_i == AXIS_W'(g));
      assign axis_err[g]   = lnk.err_active;
      assign axis_busy[g]  = lnk.busy;
      assign axis_kind[g]  = lnk.err_kind;
      assign axis_stop_o[g]  = lnk.stop;
      assign axis_error_o[g] = lnk.err_active;

      axis_fault_unit u_unit (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .enable_i   (enable_i),
        .intr_pin_i (intr_pin_i[g]),
        .lnk        (lnk.unit)
      );
    end
  endgenerate

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cmd_accept_o <= 1'b0;
      cmd_reject_o <= 1'b0;
    end
    else if (enable_i)
    begin
      cmd_accept_o <= good;
      cmd_reject_o <= cmd_valid_i & known & !good;
    end
  end

  // display follows the lowest numbered faulty axis
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      run_led_o              <= 1'b0;
      controller_error_led_o <= 1'b0;
      segment_display_code_o <= SEG_BLANK;
      segment_display_axis_o <= SEG_AX_NONE;
    end
    else if (enable_i)
    begin
      run_led_o              <= 1'b1;
      controller_error_led_o <= any_err;
      segment_display_code_o <= any_err ? SEG_CODE_ERR : SEG_BLANK;
      segment_display_axis_o <= any_err ?
        SEG_AX_BASE + SEG_AX_W'(first_axis) : SEG_AX_NONE;
    end
  end

  sequence s_cmd_taken;
    enable_i && take;
  endsequence

  property p_led;
    @(posedge clk_i) disable iff (reset_i)
    enable_i && any_err |=> run_led_o && controller_error_led_o &&
      (segment_display_code_o == SEG_CODE_ERR) &&
      (segment_display_axis_o == SEG_AX_BASE + SEG_AX_W'($past(first_axis)));
  endproperty
  a_led: assert property (p_led)
    else $error("fault not shown on lamps and display");

  property p_func;
    @(posedge clk_i) disable iff (reset_i)
    enable_i && cmd_valid_i && is_feed && latch_sel
      |=> cmd_reject_o && !cmd_accept_o;
  endproperty
  a_func: assert property (p_func)
    else $error("feed with latch input was not refused");

  property p_zero;
    @(posedge clk_i) disable iff (reset_i)
    s_cmd_taken ##0 (cmd_type_i == CMD_REL_FEED &&
      cmd_position_i == FEED_ZERO && !latch_sel)
      |=> cmd_reject_o && (axis_kind[$past(cmd_axis_i)] == ERR_REL_FEED_POS);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero travel feed not flagged");

  property p_rel_pos;
    @(posedge clk_i) disable iff (reset_i)
    s_cmd_taken ##0 (cmd_type_i == CMD_REL_MOVE && pos_bad)
      |=> axis_error_o[$past(cmd_axis_i)] && axis_stop_o[$past(cmd_axis_i)]
          && (axis_kind[$past(cmd_axis_i)] == ERR_REL_POS);
  endproperty
  a_rel_pos: assert property (p_rel_pos)
    else $error("relative position error not flagged with stop");

  property p_rel_speed;
    @(posedge clk_i) disable iff (reset_i)
    s_cmd_taken ##0 (cmd_type_i == CMD_REL_MOVE && !pos_bad && spd_bad)
      |=> (axis_kind[$past(cmd_axis_i)] == ERR_REL_SPEED) &&
          axis_error_o[$past(cmd_axis_i)] && axis_stop_o[$past(cmd_axis_i)];
  endproperty
  a_rel_speed: assert property (p_rel_speed)
    else $error("relative speed error not flagged");

  property p_good;
    @(posedge clk_i) disable iff (reset_i)
    s_cmd_taken ##0 (cmd_type_i == CMD_REL_MOVE && !pos_bad && !spd_bad &&
      !acc_bad && !dec_bad) |=> cmd_accept_o && !cmd_reject_o;
  endproperty
  a_good: assert property (p_good)
    else $error("valid relative move not accepted");
endmodule : axis_move_command_checker
`default_nettype wire

// ### host_axis_model.sv
`default_nettype none
module host_axis_model
  import axis_check_pkg::*;
(
  input  wire logic               clk_i,
  output logic                    cmd_valid_o,
  output logic [AXIS_W-1:0]       cmd_axis_o,
  output cmd_type_t               cmd_type_o,
  output logic signed [POS_W-1:0] cmd_position_o,
  output logic [SPD_W-1:0]        cmd_speed_o,
  output logic [TIME_W-1:0]       cmd_accel_o,
  output logic [TIME_W-1:0]       cmd_decel_o,
  output logic                    err_reset_o,
  output logic [AXIS_W-1:0]       err_reset_axis_o,
  output logic [NUM_AXES-1:0]     fb_overflow_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_axis_o = 4'h0;
    cmd_type_o = CMD_OTHER;
    cmd_position_o = 32'sh0;
    cmd_speed_o = 32'h0;
    cmd_accel_o = 16'h0;
    cmd_decel_o = 16'h0;
    err_reset_o = 1'b0;
    err_reset_axis_o = 4'h0;
    fb_overflow_o = 16'h0000;
  end

  // returns at the falling edge right after the taking edge
  task automatic send(input logic [AXIS_W-1:0] ax, input cmd_type_t ty,
                      input logic signed [POS_W-1:0] pos,
                      input logic [SPD_W-1:0] spd,
                      input logic [TIME_W-1:0] acc,
                      input logic [TIME_W-1:0] dec);
    @(negedge clk_i);
    cmd_axis_o = ax;
    cmd_type_o = ty;
    cmd_position_o = pos;
    cmd_speed_o = spd;
    cmd_accel_o = acc;
    cmd_decel_o = dec;
    cmd_valid_o = 1'b1;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    // scramble idle fields so a stale value cannot pass for a command
    cmd_axis_o = ~ax;
    cmd_position_o = ~pos;
    cmd_speed_o = ~spd;
    cmd_accel_o = ~acc;
    cmd_decel_o = ~dec;
  endtask : send

  task automatic err_reset(input logic [AXIS_W-1:0] ax);
    @(negedge clk_i);
    err_reset_axis_o = ax;
    err_reset_o = 1'b1;
    @(negedge clk_i);
    err_reset_o = 1'b0;
    err_reset_axis_o = ~ax;
  endtask : err_reset

  task automatic set_overflow(input logic [AXIS_W-1:0] ax);
    @(negedge clk_i);
    fb_overflow_o[ax] = 1'b1;
  endtask : set_overflow

  // reset first, then the position preset drops the overflow
  task automatic recover_overflow(input logic [AXIS_W-1:0] ax);
    err_reset(ax);
    @(negedge clk_i);
    fb_overflow_o[ax] = 1'b0;
  endtask : recover_overflow
endmodule : host_axis_model
`default_nettype wire

// ### axis_move_command_checker_test.sv
`default_nettype none
module axis_move_command_checker_test
  import axis_check_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [3:0] ax; cmd_type_t ty; logic signed [31:0] pos;
    logic [31:0] spd; logic [15:0] acc; logic [15:0] dec;
    logic latch; logic ok; logic stp;
  } row_t;

  logic        clk_i, reset_i, enable_i, cmd_valid, err_reset;
  logic [3:0]  cmd_axis, err_reset_axis;
  cmd_type_t   cmd_type;
  logic signed [31:0] cmd_position;
  logic [31:0] cmd_speed;
  logic [15:0] cmd_accel, cmd_decel, latch, pin, done, fb_ovf;
  logic [15:0] axis_error, axis_stop;
  logic        run_led, err_led, accept, reject;
  logic [7:0]  seg_code;
  logic [4:0]  seg_axis;
  int          fails = 0;
  int          checks = 0;
  row_t        rows [13];
  logic [15:0] exp;

  host_axis_model i_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid),
    .cmd_axis_o(cmd_axis), .cmd_type_o(cmd_type),
    .cmd_position_o(cmd_position), .cmd_speed_o(cmd_speed),
    .cmd_accel_o(cmd_accel), .cmd_decel_o(cmd_decel),
    .err_reset_o(err_reset), .err_reset_axis_o(err_reset_axis),
    .fb_overflow_o(fb_ovf));

  axis_move_command_checker i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .enable_i(enable_i), .cmd_valid_i(cmd_valid), .cmd_axis_i(cmd_axis),
    .cmd_type_i(cmd_type), .cmd_position_i(cmd_position),
    .cmd_speed_i(cmd_speed), .cmd_accel_i(cmd_accel),
    .cmd_decel_i(cmd_decel), .err_reset_i(err_reset),
    .err_reset_axis_i(err_reset_axis), .intr_func_latch_i(latch),
    .intr_pin_i(pin), .fb_overflow_i(fb_ovf), .move_done_i(done),
    .run_led_o(run_led), .controller_error_led_o(err_led),
    .segment_display_code_o(seg_code), .segment_display_axis_o(seg_axis),
    .axis_error_o(axis_error), .axis_stop_o(axis_stop),
    .cmd_accept_o(accept), .cmd_reject_o(reject));

  task automatic check(input logic [31:0] seen, input logic [31:0] want,
                       input string what);
    checks++;
    if (seen !== want)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h",
               $time, what, seen, want);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic good(input logic [3:0] ax, input cmd_type_t ty);
    i_host.send(ax, ty, 32'sh64, 32'h10, 16'h10, 16'h10);
  endtask : good

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    wrap_up();
  end

  initial
  begin
    rows[0]  = '{0, CMD_REL_MOVE, 1, 1, 0, 0, 0, 1, 0};
    rows[1]  = '{1, CMD_REL_MOVE, REL_POS_MAX, SPEED_MAX, ACC_MAX, DEC_MAX,
                 0, 1, 0};
    rows[2]  = '{2, CMD_REL_MOVE, 32'sh4000_0000, 1, 0, 0, 0, 0, 1};
    rows[3]  = '{3, CMD_REL_MOVE, 32'shc000_0000, 1, 0, 0, 0, 0, 1};
    rows[4]  = '{4, CMD_REL_MOVE, 1, 0, 0, 0, 0, 0, 1};
    rows[5]  = '{5, CMD_REL_MOVE, 1, 32'h4000_0000, 0, 0, 0, 0, 1};
    rows[6]  = '{6, CMD_REL_MOVE, 1, 1, 16'h2711, 0, 0, 0, 1};
    rows[7]  = '{7, CMD_REL_MOVE, 1, 1, 0, 16'h2711, 0, 0, 1};
    rows[8]  = '{8, CMD_REL_FEED, FEED_ZERO, 1, 0, 0, 0, 0, 1};
    rows[9]  = '{9, CMD_REL_FEED, 32'sh4000_0000, 1, 0, 0, 0, 0, 1};
    rows[10] = '{10, CMD_REL_FEED, 5, 1, 0, 0, 1, 0, 0};
    rows[11] = '{11, CMD_ABS_FEED, 5, 1, 0, 0, 1, 0, 0};
    rows[12] = '{15, CMD_REL_MOVE, 1, 0, 0, 0, 0, 0, 1};
    reset_i = 1'b1;
    enable_i = 1'b1;
    latch = '0;
    pin = '0;
    done = '0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    check(run_led, 0, "run lamp in reset");
    check({err_led, seg_code, seg_axis}, 0, "display in reset");
    check({axis_error, axis_stop}, 0, "axis flags in reset");
    reset_i = 1'b0;
    @(negedge clk_i);
    check(run_led, 1, "run lamp");

    foreach (rows[i])
    begin
      latch = '0;
      latch[rows[i].ax] = rows[i].latch;
      i_host.send(rows[i].ax, rows[i].ty, rows[i].pos, rows[i].spd,
                  rows[i].acc, rows[i].dec);
      exp = rows[i].ok ? 16'h0 : (16'h1 << rows[i].ax);
      check(accept, rows[i].ok, "accept");
      check(reject, !rows[i].ok, "reject");
      check(axis_error, exp, "error flag");
      check(axis_stop, rows[i].stp ? exp : 16'h0, "stop");
      @(negedge clk_i);
      check(err_led, !rows[i].ok, "error lamp");
      check(seg_code, rows[i].ok ? SEG_BLANK : SEG_CODE_ERR, "code");
      check(seg_axis, rows[i].ok ? SEG_AX_NONE
            : SEG_AX_BASE + {1'b0, rows[i].ax}, "axis number");
      if (!rows[i].ok)
      begin
        repeat (5) @(negedge clk_i);
        check(axis_error, exp, "error held");
        i_host.err_reset(rows[i].ax);
        check({axis_error, axis_stop}, 0, "error cleared");
        @(negedge clk_i);
        check({err_led, seg_code}, 0, "lamp cleared");
      end
    end
    latch = '0;

    // faulty axis refuses, neighbour keeps moving
    i_host.send(2, CMD_REL_MOVE, 1, 0, 0, 0);
    good(2, CMD_REL_MOVE);
    check({accept, reject}, 2'b01, "refused on faulty axis");
    good(3, CMD_REL_MOVE);
    check(accept, 1, "neighbour accepted");
    check({axis_error, axis_stop}, {16'h4, 16'h4}, "only axis 2");
    i_host.err_reset(2);

    // no answer while disabled or for other commands
    enable_i = 1'b0;
    i_host.send(0, CMD_REL_MOVE, 1, 0, 0, 0);
    check({accept, reject, axis_error}, 0, "disabled");
    enable_i = 1'b1;
    i_host.send(0, CMD_OTHER, 1, 0, 0, 0);
    check({accept, reject, axis_error}, 0, "other command");

    // feed that sees its interrupt finishes cleanly
    good(4, CMD_REL_FEED);
    check(accept, 1, "feed accepted");
    good(4, CMD_REL_MOVE);
    check({reject, axis_error}, 17'h10000, "busy feeding");
    pin[4] = 1'b1;
    repeat (4) @(negedge clk_i);
    done[4] = 1'b1;
    @(negedge clk_i);
    done[4] = 1'b0;
    @(negedge clk_i);
    check(axis_error, 0, "interrupt seen");
    pin[4] = 1'b0;
    good(4, CMD_REL_MOVE);
    check(accept, 1, "axis free again");

    // feed ending with no interrupt
    good(5, CMD_ABS_FEED);
    done[5] = 1'b1;
    @(negedge clk_i);
    done[5] = 1'b0;
    check({axis_error, axis_stop}, {16'h20, 16'h0}, "no interrupt");
    @(negedge clk_i);
    check({seg_code, seg_axis}, {SEG_CODE_ERR, 5'h06}, "display");
    i_host.err_reset(5);

    // overflow while feeding stops the axis until recovery
    good(6, CMD_REL_FEED);
    i_host.set_overflow(6);
    @(negedge clk_i);
    check({axis_error, axis_stop}, {16'h40, 16'h40}, "ovf");
    i_host.recover_overflow(6);
    @(negedge clk_i);
    check({axis_error, axis_stop}, 0, "overflow recovered");
    good(6, CMD_REL_MOVE);
    check(accept, 1, "after recovery");

    // reset in mid-run drops a held error at once
    i_host.send(1, CMD_REL_MOVE, 1, 0, 0, 0);
    reset_i = 1'b1;
    @(negedge clk_i);
    check({axis_error, axis_stop}, 0, "mid-run reset");
    check(run_led, 0, "run lamp in mid-run reset");
    reset_i = 1'b0;
    good(1, CMD_REL_MOVE);
    check(accept, 1, "first command after reset");
    check(axis_error, 0, "no error after reset");
    wrap_up();
  end
endmodule : axis_move_command_checker_test
`default_nettype wire
